// ### src/rpda_pkg.sv
// constants, types and helpers of the ram port dma arbiter
//------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------
// Summary of operation
// - ram decoded at base 0x20000000, 64 kB in this build
// - ram is 32 bits wide; byte, half-word and word accesses accepted
// - zero wait states normally; one wait state in fast clock mode, more while the answer buffer is full
// - each serial controller has separate receive and transmit channels
// - dma channels reach the ram directly, not through the processor bus
// - fixed priority arbitration still guarantees the processor ram slots
// - dma order: usb, adc, sc2 rx/tx, sc4 rx/tx, mac, sc1 rx/tx, sc3 rx/tx
package rpda_pkg;

  //------------------------------------------------------------------
  // sizes
  //------------------------------------------------------------------
  localparam int          NDMA      = 11;
  localparam int          RAM_AW    = 16;               // byte address bits, 64 kB
  localparam int          RAM_WORDS = 1 << (RAM_AW - 2);
  localparam int          BUF_DEPTH = 2;
  localparam int          ID_W      = 4;
  localparam logic [31:0] RAM_BASE  = 32'h2000_0000;
  localparam logic [31:0] RAM_MASK  = 32'hFFFF_0000;   // base compare bits
  localparam logic [3:0]  ID_CPU    = 4'hF;            // answer tag of the processor

  //------------------------------------------------------------------
  // dma channel slots, index 0 is the highest priority
  //------------------------------------------------------------------
  localparam int CH_USB    = 0;
  localparam int CH_ADC    = 1;
  localparam int CH_SC2_RX = 2;
  localparam int CH_SC2_TX = 3;
  localparam int CH_SC4_RX = 4;
  localparam int CH_SC4_TX = 5;
  localparam int CH_MAC    = 6;
  localparam int CH_SC1_RX = 7;
  localparam int CH_SC1_TX = 8;
  localparam int CH_SC3_RX = 9;
  localparam int CH_SC3_TX = 10;

  //------------------------------------------------------------------
  // access sizes
  //------------------------------------------------------------------
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  typedef struct packed {
    logic        vld;
    logic        wr;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rpda_req_t;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic            err;
    logic [31:0]     rdata;
  } rpda_rsp_t;

  // byte lanes touched by an access
  function automatic logic [3:0] rpda_lanes(input logic [1:0] size, input logic [1:0] a);
    logic [3:0] be;
    be = 4'hF;
    if (size == SZ_BYTE)
      be = 4'h1 << a;
    else if (size == SZ_HALF)
      be = a[1] ? 4'hC : 4'h3;
    return be;
  endfunction

  // address inside ram, size legal and aligned
  function automatic logic rpda_legal(input rpda_req_t r);
    logic ok;
    ok = (r.addr & RAM_MASK) == RAM_BASE;
    if (r.size == SZ_HALF && r.addr[0])
      ok = 1'b0;
    if (r.size == SZ_WORD && r.addr[1:0] != 2'h0)
      ok = 1'b0;
    if (r.size != SZ_BYTE && r.size != SZ_HALF && r.size != SZ_WORD)
      ok = 1'b0;
    return ok;
  endfunction

endpackage

// ### src/rpda_top.sv
// ram port with fixed priority arbiter between processor and dma channels
`timescale 1ns/10ps
module rpda_top (
  input  wire logic                                    clk_i,
  input  wire logic                                    rst_n_i,
  input  wire logic                                    fast_mode_i,
  input  wire logic                                    usb_present_i,
  input  wire rpda_pkg::rpda_req_t                     cpu_req_i,
  input  wire rpda_pkg::rpda_req_t [rpda_pkg::NDMA-1:0] dma_req_i,
  output logic                                         cpu_gnt_o,
  output logic [rpda_pkg::NDMA-1:0]                    dma_gnt_o,
  output logic                                         rsp_valid_o,
  input  wire logic                                    rsp_ready_i,
  output rpda_pkg::rpda_rsp_t                          rsp_o
);
  import rpda_pkg::*;

  typedef enum logic {ST_IDLE, ST_WAIT} rpda_state_t;

  rpda_state_t     st_ff, nxt_st;
  rpda_req_t       op_ff, nxt_op;
  logic [ID_W-1:0] opid_ff, nxt_opid;
  logic            cpu_turn_ff, nxt_cpu_turn;
  rpda_rsp_t       buf_ff [BUF_DEPTH];
  rpda_rsp_t       nxt_buf [BUF_DEPTH];
  logic            wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [1:0]      cnt_ff, nxt_cnt;
  logic [31:0]     mem [RAM_WORDS];

  logic [NDMA-1:0] dma_vld, dma_pick;
  logic            cpu_win, can_grant, any_gnt;
  logic            push_ok, push, pop;
  rpda_req_t       sel_req, acc_req;
  logic [ID_W-1:0] sel_id, acc_id;
  logic            acc_ok;
  logic [3:0]      acc_be;
  logic [RAM_AW-3:0] acc_idx;
  rpda_rsp_t       acc_rsp;

  //------------------------------------------------------------------
  // arbitration
  //------------------------------------------------------------------
  // request vector in priority order, absent usb masked
  always_comb
  begin
    for (int i = 0; i < NDMA; i++)
      dma_vld[i] = dma_req_i[i].vld;
    dma_vld[CH_USB] = dma_req_i[CH_USB].vld && usb_present_i;
  end

  // lowest index wins among dma, processor gets every other slot
  always_comb
  begin
    dma_pick  = dma_vld & (~dma_vld + 1'b1);
    cpu_win   = cpu_req_i.vld && (cpu_turn_ff || dma_vld == '0);
    can_grant = (st_ff == ST_IDLE) && (fast_mode_i || push_ok);
    cpu_gnt_o = can_grant && cpu_win;
    dma_gnt_o = (can_grant && !cpu_win) ? dma_pick : '0;
    any_gnt   = cpu_gnt_o || (dma_gnt_o != '0);
  end

  // winner's request and answer tag; dma path never touches the cpu bus
  always_comb
  begin
    sel_req = cpu_req_i;
    sel_id  = ID_CPU;
    if (!cpu_win)
    begin
      for (int i = 0; i < NDMA; i++)
        if (dma_pick[i])
        begin
          sel_req = dma_req_i[i];
          sel_id  = ID_W'(i);
        end
    end
  end

  //------------------------------------------------------------------
  // access sequencer
  //------------------------------------------------------------------
  // fast mode parks the granted request in the wait state for one cycle, longer while the answer buffer is full
  always_comb
  begin
    nxt_st   = st_ff;
    nxt_op   = op_ff;
    nxt_opid = opid_ff;
    acc_req  = sel_req;
    acc_id   = sel_id;
    push     = 1'b0;
    if (st_ff == ST_WAIT)
    begin
      acc_req = op_ff;
      acc_id  = opid_ff;
      if (push_ok)
      begin
        push   = 1'b1;
        nxt_st = ST_IDLE;
      end
    end
    else if (any_gnt && fast_mode_i)
    begin
      nxt_st   = ST_WAIT;
      nxt_op   = sel_req;
      nxt_opid = sel_id;
    end
    else if (any_gnt)
      push = 1'b1;
  end

  // processor turn after a dma grant taken while it waited
  always_comb
  begin
    nxt_cpu_turn = cpu_turn_ff;
    if (cpu_gnt_o || !cpu_req_i.vld)
      nxt_cpu_turn = 1'b0;
    else if (dma_gnt_o != '0)
      nxt_cpu_turn = 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_ff       <= ST_IDLE;
      op_ff       <= '0;
      opid_ff     <= '0;
      cpu_turn_ff <= 1'b0;
    end
    else
    begin
      st_ff       <= nxt_st;
      op_ff       <= nxt_op;
      opid_ff     <= nxt_opid;
      cpu_turn_ff <= nxt_cpu_turn;
    end
  end

  //------------------------------------------------------------------
  // ram array
  //------------------------------------------------------------------
  // decode, lanes and read data of the current access
  always_comb
  begin
    acc_ok        = rpda_legal(acc_req);
    acc_be        = rpda_lanes(acc_req.size, acc_req.addr[1:0]);
    acc_idx       = acc_req.addr[RAM_AW-1:2];
    acc_rsp.id    = acc_id;
    acc_rsp.err   = !acc_ok;
    acc_rsp.rdata = (acc_ok && !acc_req.wr) ? mem[acc_idx] : '0;
  end

  // byte-lane write, illegal accesses leave the ram untouched
  always_ff @(posedge clk_i)
  begin
    if (push && acc_ok && acc_req.wr)
      for (int b = 0; b < 4; b++)
        if (acc_be[b])
          mem[acc_idx][8*b +: 8] <= acc_req.wdata[8*b +: 8];
  end

  //------------------------------------------------------------------
  // two-entry answer buffer
  //------------------------------------------------------------------
  assign push_ok     = cnt_ff != 2'(BUF_DEPTH);
  assign rsp_valid_o = cnt_ff != 2'h0;
  assign pop         = rsp_valid_o && rsp_ready_i;
  assign rsp_o       = buf_ff[rp_ff];

  // pointers and count
  always_comb
  begin
    nxt_buf = buf_ff;
    nxt_wp  = wp_ff;
    nxt_rp  = rp_ff;
    nxt_cnt = cnt_ff;
    if (push)
    begin
      nxt_buf[wp_ff] = acc_rsp;
      nxt_wp         = ~wp_ff;
    end
    if (pop)
      nxt_rp = ~rp_ff;
    if (push && !pop)
      nxt_cnt = cnt_ff + 2'h1;
    else if (pop && !push)
      nxt_cnt = cnt_ff - 2'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      buf_ff <= '{default: '0};
      wp_ff  <= 1'b0;
      rp_ff  <= 1'b0;
      cnt_ff <= 2'h0;
    end
    else
    begin
      buf_ff <= nxt_buf;
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  //------------------------------------------------------------------
  // checks
  //------------------------------------------------------------------
  ram_decode_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    push && ((acc_req.addr & RAM_MASK) != RAM_BASE) |-> acc_rsp.err)
    else $error("access outside ram not flagged");

  byte_lane_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    push && acc_ok && acc_req.size == SZ_BYTE |-> $onehot(acc_be))
    else $error("byte access touches more than one lane");

  zero_wait_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    any_gnt && !fast_mode_i && cnt_ff == 2'h0 |=> rsp_valid_o && rsp_o.id == $past(sel_id))
    else $error("normal mode answer not ready next cycle");

  one_wait_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    any_gnt && fast_mode_i && cnt_ff == 2'h0 && !rsp_valid_o |=> !any_gnt && !rsp_valid_o ##1 rsp_valid_o)
    else $error("fast mode did not insert exactly one wait state");

  // receive grant with transmit pending must store the receive tag, not the transmit one
  duplex_pair_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    dma_gnt_o[CH_SC1_RX] && dma_req_i[CH_SC1_TX].vld && !fast_mode_i
      |=> buf_ff[$past(wp_ff)].id == ID_W'(CH_SC1_RX))
    else $error("receive grant carried transmit request");

  cpu_share_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    dma_gnt_o != '0 && cpu_req_i.vld ##1 cpu_req_i.vld && can_grant |-> cpu_gnt_o)
    else $error("processor skipped after dma grant");

  dma_order_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    dma_gnt_o != '0 |-> ((dma_gnt_o - 1'b1) & dma_vld) == '0 && (dma_gnt_o & dma_vld) != '0)
    else $error("dma grant skipped a higher request");

  one_grant_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $onehot0({cpu_gnt_o, dma_gnt_o}) && !(!usb_present_i && dma_gnt_o[CH_USB]))
    else $error("more than one grant or absent usb granted");

endmodule // rpda_top

// ### tb/rpda_sink.sv
// receiving end of the answer stream, able to stall
`timescale 1ns/10ps
module rpda_sink (
  input  wire logic clk_i,
  input  wire logic stall_i,
  output logic      rsp_ready_o
);
  // ready follows the stall request one edge later, like a registered receiver
  always @(posedge clk_i) rsp_ready_o <= !stall_i;
endmodule // rpda_sink

// ### tb/rpda_top_tb.sv
// self-checking bench of the ram port dma arbiter
`timescale 1ns/10ps
module rpda_top_tb;
  import rpda_pkg::*;
  typedef struct {int ch; logic wr; logic [1:0] sz; logic [31:0] a; logic [31:0] d; logic e; logic [31:0] r;} rpda_row_t;
  localparam int CPU = 11;
  logic                 clk         = 1'h0;
  logic                 rst_n       = 1'h0;
  logic                 fast        = 1'h0;
  logic                 usb         = 1'h0;
  logic                 stall       = 1'h0;
  rpda_req_t            cpu_req     = '0;
  rpda_req_t [NDMA-1:0] dma_req     = '0;
  logic                 cpu_gnt;
  logic [NDMA-1:0]      dma_gnt;
  logic                 rsp_valid;
  logic                 rsp_ready;
  rpda_rsp_t            rsp;
  int                   n_errors    = 0;
  int                   comparisons = 0;
  logic [3:0]           got[$];
  int                   order[11]   = '{1, CPU, 2, 3, 4, 5, 6, 7, 8, 9, 10};
  // legal byte and half writes carry the byte in every lane so lane placement cannot matter
  rpda_row_t rows[12] = '{
    '{CPU, 1, SZ_WORD, 32'h2000_0010, 32'h1122_3344, 0, 0},
    '{1, 1, SZ_BYTE, 32'h2000_0011, 32'hAAAA_AAAA, 0, 0},
    '{3, 1, SZ_HALF, 32'h2000_0012, 32'hBBBB_BBBB, 0, 0},
    '{10, 0, SZ_WORD, 32'h2000_0010, 0, 0, 32'hBBBB_AA44},
    '{CPU, 0, SZ_BYTE, 32'h2000_0013, 0, 0, 32'hBBBB_AA44},
    '{6, 1, SZ_WORD, 32'h2000_FFFC, 32'h5A5A_C3C3, 0, 0},
    '{8, 0, SZ_HALF, 32'h2000_FFFE, 0, 0, 32'h5A5A_C3C3},
    '{2, 0, SZ_WORD, 32'h2001_0000, 0, 1, 0},
    '{4, 1, SZ_HALF, 32'h2000_0011, 32'h0000_FFFF, 1, 0},
    '{5, 0, SZ_WORD, 32'h2000_0012, 0, 1, 0},
    '{7, 0, 2'h3, 32'h2000_0010, 0, 1, 0},
    '{9, 0, SZ_WORD, 32'h2000_0010, 0, 0, 32'hBBBB_AA44}};

  rpda_top DUT (.clk_i(clk), .rst_n_i(rst_n), .fast_mode_i(fast), .usb_present_i(usb), .cpu_req_i(cpu_req),
    .dma_req_i(dma_req), .cpu_gnt_o(cpu_gnt), .dma_gnt_o(dma_gnt), .rsp_valid_o(rsp_valid),
    .rsp_ready_i(rsp_ready), .rsp_o(rsp));
  rpda_sink far (.clk_i(clk), .stall_i(stall), .rsp_ready_o(rsp_ready));

  // clock and answer monitor
  always #20 clk = ~clk;
  always @(posedge clk) if (rsp_valid === 1'h1 && rsp_ready === 1'h1) got.push_back(rsp.id);

  //------------------------------------------------------------------
  // helpers
  //------------------------------------------------------------------
  task chk(string nm, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, s);
      n_errors++;
    end
  endtask

  function automatic logic g(int ch);
    logic [11:0] v;
    v = {cpu_gnt, dma_gnt};
    return v[ch];
  endfunction

  task put(int ch, logic wr, logic [1:0] sz, logic [31:0] a, logic [31:0] d);
    if (ch == CPU) cpu_req = '{1'h1, wr, sz, a, d};
    else dma_req[ch] = '{1'h1, wr, sz, a, d};
  endtask

  task drop(int ch);
    if (ch == CPU) cpu_req = '0;
    else dma_req[ch] = '0;
  endtask

  // wait for the grant, let the taking edge pass, then release
  task grab(int ch);
    int i;
    #1;
    for (i = 0; i < 20 && g(ch) !== 1'h1; i++)
    begin
      @(negedge clk);
      #1;
    end
    chk("grant", 1, g(ch));
    @(posedge clk);
    @(negedge clk);
    drop(ch);
  endtask

  task xfer(rpda_row_t t);
    int i;
    @(negedge clk);
    put(t.ch, t.wr, t.sz, t.a, t.d);
    grab(t.ch);
    for (i = 0; i < 10 && rsp_valid !== 1'h1; i++) @(negedge clk);
    chk("latency", 0, i);
    chk("id", (t.ch == CPU) ? ID_CPU : 4'(t.ch), rsp.id);
    chk("err", t.e, rsp.err);
    chk("rdata", t.r, rsp.rdata);
  endtask

  task conclude();
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  //------------------------------------------------------------------
  // tests
  //------------------------------------------------------------------
  initial
  begin
    repeat (20) @(negedge clk);
    chk("reset valid", 0, rsp_valid);
    rst_n = 1'h1;
    foreach (rows[k]) xfer(rows[k]);
    // every channel and the processor at once, usb slot absent
    @(negedge clk);
    for (int c = 0; c < NDMA; c++) put(c, 1'h0, SZ_WORD, RAM_BASE, 32'h0);
    put(CPU, 1'h0, SZ_WORD, RAM_BASE, 32'h0);
    foreach (order[k])
    begin
      #1 chk("ladder", 12'h1 << order[k], {cpu_gnt, dma_gnt});
      @(negedge clk);
      drop(order[k]);
    end
    #1 chk("usb absent", 0, {cpu_gnt, dma_gnt});
    @(negedge clk);
    usb = 1'h1;
    put(1, 1'h0, SZ_WORD, RAM_BASE, 32'h0);
    #1 chk("usb first", 1, {cpu_gnt, dma_gnt});
    @(negedge clk);
    drop(0);
    #1 chk("adc after usb", 2, {cpu_gnt, dma_gnt});
    @(negedge clk);
    drop(1);
    repeat (3) @(negedge clk);
    // fast mode: one wait state, then the waiting processor wins
    fast = 1'h1;
    put(1, 1'h0, SZ_WORD, RAM_BASE, 32'h0);
    put(CPU, 1'h0, SZ_WORD, RAM_BASE, 32'h0);
    #1 chk("fast grant", 12'h2, {cpu_gnt, dma_gnt});
    @(negedge clk);
    drop(1);
    #1 chk("wait grant", 0, {cpu_gnt, dma_gnt});
    chk("wait valid", 0, rsp_valid);
    @(negedge clk);
    chk("fast valid", 1, rsp_valid);
    chk("cpu turn", 12'h800, {cpu_gnt, dma_gnt});
    @(negedge clk);
    drop(CPU);
    fast = 1'h0;
    repeat (4) @(negedge clk);
    // receiver stalls: two answers held, third request refused
    got.delete();
    stall = 1'h1;
    repeat (2) @(negedge clk);
    for (int c = 7; c < 9; c++)
    begin
      put(c, 1'h0, SZ_WORD, RAM_BASE, 32'h0);
      grab(c);
    end
    put(9, 1'h0, SZ_WORD, RAM_BASE, 32'h0);
    repeat (3)
    begin
      #1 chk("full", 0, dma_gnt[9]);
      @(negedge clk);
    end
    stall = 1'h0;
    grab(9);
    repeat (4) @(negedge clk);
    chk("answers", 3, got.size());
    foreach (got[k]) chk("answer id", 7 + k, got[k]);
    // reset in mid-run drops a held answer and leaves the port idle
    stall = 1'h1;
    repeat (2) @(negedge clk);
    put(10, 1'h0, SZ_WORD, RAM_BASE, 32'h0);
    grab(10);
    chk("held valid", 1, rsp_valid);
    rst_n = 1'h0;
    @(negedge clk);
    chk("reset flush", 0, rsp_valid);
    rst_n = 1'h1;
    stall = 1'h0;
    repeat (2) @(negedge clk);
    chk("after reset", 0, rsp_valid);
    conclude();
  end

  // watchdog, well beyond the fewer than a hundred cycles the tests need
  initial
  begin
    #(40 * 5000);
    n_errors++;
    conclude();
  end
endmodule // rpda_top_tb
